// ---- hw/cpb_level.sv ----
// Purpose: Output level mapping of one complementary phase pair
// Assumes: Raw positive and negative waveforms come from the counter logic
// Notes: Purely combinational
`timescale 1ns/1ps
module cpb_level (
  input wire logic raw_pos,
  input wire logic raw_neg,
  input wire logic pos_level,
  input wire logic neg_level,
  input wire logic deadtime_enable,
  output logic out_pos,
  output logic out_neg
);
  // Negative level follows inverted positive level without dead time
  always_comb begin
    out_pos = raw_pos ^ ~pos_level;
    if (deadtime_enable) begin
      out_neg = raw_neg ^ ~neg_level;
    end else begin
      out_neg = ~(raw_pos ^ ~pos_level);
    end
  end
endmodule

// ---- hw/cpb_top.sv ----
// Purpose: Buffered register update and output levels of one timer pair
// Assumes: Software writes buffers over plain ports; same clock domain
// Notes: Two identical pairs are two instances of this module
`timescale 1ns/1ps
`include "cpb_regs.svh"
module cpb_top #(
  parameter int DATA_W = `CPB_DATA_W
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic buf_wr,
  input wire cpb_pkg::cpb_idx_t buf_idx,
  input wire cpb_pkg::cpb_data_t buf_wdata,
  input wire logic buffer_mode_a,
  input wire logic buffer_mode_b,
  input wire logic deadtime_enable,
  input wire logic pos_level_sel,
  input wire logic neg_level_sel,
  input wire logic [`CPB_NUM_PHASE-1:0] phase_pos_level_sel,
  input wire logic [`CPB_NUM_PHASE-1:0] phase_neg_level_sel,
  input wire logic [7:0] io_control_reg,
  input wire logic [`CPB_NUM_PHASE:0] raw_pos,
  input wire logic [`CPB_NUM_PHASE:0] raw_neg,
  output cpb_pkg::cpb_data_t tmp_period,
  output cpb_pkg::cpb_data_t tmp_cycle_a,
  output cpb_pkg::cpb_data_t tmp_cycle_b,
  output cpb_pkg::cpb_data_t tmp_duty_a,
  output cpb_pkg::cpb_data_t tmp_duty_d,
  output logic xfer_pulse,
  output logic io_ctrl_bad,
  output logic [`CPB_NUM_PHASE:0] out_pos,
  output logic [`CPB_NUM_PHASE:0] out_neg,
  output logic ch3_c_pin_oe_b,
  output logic ch4_c_pin,
  output logic ch4_d_pin,
  output logic ch4_oe_b
);
  import cpb_pkg::*;

  typedef struct packed {
    cpb_data_t [`CPB_NUM_BUF-1:0] bufr;
    cpb_data_t [`CPB_NUM_BUF-1:0] tmp;
    logic xfer;
    logic [`CPB_NUM_PHASE:0] pos;
    logic [`CPB_NUM_PHASE:0] neg;
  } cpb_state_s_t;

  cpb_state_s_t st_ff;
  cpb_state_s_t nxt_st;
  logic [`CPB_NUM_PHASE:0] lvl_pos;
  logic [`CPB_NUM_PHASE:0] lvl_neg;
  logic [`CPB_NUM_PHASE:0] map_pos;
  logic [`CPB_NUM_PHASE:0] map_neg;

  initial begin
    if (DATA_W != `CPB_DATA_W) begin
      $error("DATA_W must match package data width");
    end
  end

  // Level select: index 0 is the common pair, 1..4 the phases 0..3
  assign lvl_pos = {phase_pos_level_sel, pos_level_sel};
  assign lvl_neg = {phase_neg_level_sel, neg_level_sel};

  // One level mapper per output pair
  genvar g;
  generate
    for (g = 0; g <= `CPB_NUM_PHASE; g++) begin : g_lvl
      cpb_level u_lvl (
        .raw_pos(raw_pos[g]),
        .raw_neg(raw_neg[g]),
        .pos_level(lvl_pos[g]),
        .neg_level(lvl_neg[g]),
        .deadtime_enable(deadtime_enable),
        .out_pos(map_pos[g]),
        .out_neg(map_neg[g])
      );
    end
  endgenerate

  // Buffer writes and the simultaneous transfer into temporaries
  always_comb begin
    nxt_st = st_ff;
    nxt_st.xfer = 1'b0;
    nxt_st.pos = map_pos;
    nxt_st.neg = map_neg;
    if (buf_wr && (buf_idx < 3'(`CPB_NUM_BUF))) begin
      nxt_st.bufr[buf_idx] = buf_wdata;
      if (buf_idx == `CPB_IDX_DUTY_D) begin
        nxt_st.tmp = nxt_st.bufr;
        nxt_st.xfer = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tmp_period = st_ff.tmp[`CPB_IDX_PERIOD];
  assign tmp_cycle_a = st_ff.tmp[`CPB_IDX_CYCLE_A];
  assign tmp_cycle_b = st_ff.tmp[`CPB_IDX_CYCLE_B];
  assign tmp_duty_a = st_ff.tmp[`CPB_IDX_DUTY_A];
  assign tmp_duty_d = st_ff.tmp[`CPB_IDX_DUTY_D];
  assign xfer_pulse = st_ff.xfer;
  assign out_pos = st_ff.pos;
  assign out_neg = st_ff.neg;

  // Flag a non-zero I/O control setting while in complementary mode
  assign io_ctrl_bad = (io_control_reg != `CPB_IO_CTRL_CMPL);

  // Third channel C pin is never driven by the timer
  assign ch3_c_pin_oe_b = 1'b1;

  // Channel four auxiliary outputs silenced when buffer mode is set
  assign ch4_oe_b = buffer_mode_a | buffer_mode_b;
  assign ch4_c_pin = ch4_oe_b ? 1'b0 : st_ff.pos[`CPB_NUM_PHASE];
  assign ch4_d_pin = ch4_oe_b ? 1'b0 : st_ff.neg[`CPB_NUM_PHASE];
endmodule

// ---- inc/cpb_pkg.sv ----
// Purpose: Shared types for the complementary PWM buffer block
// Assumes: cpb_regs.svh supplies widths
// Notes: Buffer index selects one of five buffered registers
package cpb_pkg;
`include "cpb_regs.svh"
  typedef logic [`CPB_DATA_W-1:0] cpb_data_t;
  typedef logic [2:0] cpb_idx_t;
  typedef enum logic [0:0] {
    CPB_IDLE = 1'b0,
    CPB_XFER = 1'b1
  } cpb_state_t;
endpackage

// ---- inc/cpb_regs.svh ----
// Purpose: Constants for the complementary PWM buffer and output level block
// Assumes: Included by bare name from the package and design files
// Notes: Timer registers are 16 bits wide
`ifndef CPB_REGS_SVH
`define CPB_REGS_SVH
`define CPB_DATA_W 16
`define CPB_NUM_BUF 5
`define CPB_NUM_PHASE 4
`define CPB_IO_CTRL_CMPL 8'h00
`define CPB_DATA_RST 16'h0000
`define CPB_IDX_PERIOD 3'h0
`define CPB_IDX_CYCLE_A 3'h1
`define CPB_IDX_CYCLE_B 3'h2
`define CPB_IDX_DUTY_A 3'h3
`define CPB_IDX_DUTY_D 3'h4
`endif

// ---- test/complementary_pwm_buffer_output_bench.sv ----
// Purpose: Bench of cpb_top
// Assumes: Inputs change at falling edge
// Notes: Transfers scored through a queue
`timescale 1ns/1ps
module complementary_pwm_buffer_output_bench;
  import cpb_pkg::*;
  logic clk = 0, rst_b = 0, buf_wr = 0, bfa = 0, bfb = 0, dte = 0, ps = 0, ns = 0;
  logic [3:0] pp = 0, pn = 0;
  logic [4:0] rp = 0, rn = 0;
  logic [7:0] ioc = 0;
  logic [79:0] q[$], last = 0;
  logic [4:0] op, on, ep, en;
  logic xp, icb, c3, c4c, c4d, c4oe;
  logic [14:0] lq[$], le;
  cpb_idx_t idx = 0;
  cpb_data_t wd = 0, tp, ta, tb, tda, tdd, b[5] = '{default: 0};
  int miscompares = 0, cmp_count = 0;
  cpb_top dut_u (.clk, .rst_b, .buf_wr, .buf_idx(idx), .buf_wdata(wd), .buffer_mode_a(bfa),
    .buffer_mode_b(bfb), .deadtime_enable(dte), .pos_level_sel(ps), .neg_level_sel(ns),
    .phase_pos_level_sel(pp), .phase_neg_level_sel(pn), .io_control_reg(ioc),
    .raw_pos(rp), .raw_neg(rn), .tmp_period(tp), .tmp_cycle_a(ta), .tmp_cycle_b(tb),
    .tmp_duty_a(tda), .tmp_duty_d(tdd), .xfer_pulse(xp), .io_ctrl_bad(icb), .out_pos(op),
    .out_neg(on), .ch3_c_pin_oe_b(c3), .ch4_c_pin(c4c), .ch4_d_pin(c4d), .ch4_oe_b(c4oe));
  always #4 clk = ~clk;
  task chk(input string n, input logic [79:0] e, input logic [79:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task results;
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Write one buffer and note the expected transfer
  task wr(input int i, input cpb_data_t d);
    @(negedge clk);
    {buf_wr, idx, wd} = {1'b1, cpb_idx_t'(i), d};
    if (i < 5) b[i] = d;
    last = (i == 4) ? {b[0], b[1], b[2], b[3], b[4]} : last;
    if (i == 4) q.push_back(last);
  endtask
  // Score each transfer pulse
  always @(posedge clk) begin
    #1;
    if (xp === 1'b1)
      chk("tmp", q.size() > 0 ? q.pop_front() : 'x, {tp, ta, tb, tda, tdd});
  end
  // Score level and pin outputs one edge after each random drive
  always @(posedge clk) begin
    #1;
    if (lq.size() > 0) begin
      le = lq.pop_front();
      chk("out_pos", le[14:10], op);
      chk("out_neg", le[9:5], on);
      chk("ch4_oe_b", le[4], c4oe);
      chk("ch4_c_pin", le[3], c4c);
      chk("ch4_d_pin", le[2], c4d);
      chk("io_ctrl_bad", le[1], icb);
      chk("ch3_c_pin_oe_b", le[0], c3);
    end
  end
  initial begin
    void'($urandom(70024));
    repeat (2) @(posedge clk);
    @(negedge clk) rst_b = 1;
    for (int i = 0; i < 5; i++) wr(i, cpb_data_t'($urandom));
    wr(4, b[4]);
    for (int i = 1; i < 8; i += 2) wr(i, cpb_data_t'($urandom));
    @(negedge clk) buf_wr = 0;
    repeat (2) @(negedge clk);
    chk("hold", last, {tp, ta, tb, tda, tdd});
    wr(4, b[4]);
    @(negedge clk) buf_wr = 0;
    repeat (200) begin
      @(negedge clk);
      {bfa, bfb, dte, ps, ns, pp, pn, rp, rn, ioc} = 31'($urandom);
      ep = ~(rp ^ {pp, ps});
      en = dte ? ~(rn ^ {pn, ns}) : ~ep;
      lq.push_back({ep, en, bfa | bfb, (bfa | bfb) ? 1'b0 : ep[4],
        (bfa | bfb) ? 1'b0 : en[4], ioc != 8'h00, 1'b1});
    end
    @(posedge clk);
    #2;
    chk("pending", 0, q.size() + lq.size());
    results();
  end
  initial begin
    #20000;
    miscompares++;
    results();
  end
endmodule

// ---- test/cpb_properties.sv ----
// Purpose: Port checks of cpb_top
// Assumes: One clock domain
// Notes: Bound after the module
`timescale 1ns/1ps
module cpb_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic buf_wr,
  input wire cpb_pkg::cpb_idx_t buf_idx,
  input wire logic buffer_mode_a,
  input wire logic buffer_mode_b,
  input wire logic deadtime_enable,
  input wire logic pos_level_sel,
  input wire logic [3:0] phase_pos_level_sel,
  input wire logic [4:0] raw_pos,
  input wire logic xfer_pulse,
  input wire logic [4:0] out_pos,
  input wire logic [4:0] out_neg,
  input wire logic ch3_c_pin_oe_b,
  input wire logic ch4_oe_b,
  input wire logic ch4_c_pin,
  input wire logic ch4_d_pin
);
  import cpb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Pin, transfer, blocking and level relations
  AST_C_IDLE: assert property (ch3_c_pin_oe_b) else $error("c pin driven");
  AST_XFER: assert property (buf_wr && buf_idx == 3'h4 |=> xfer_pulse) else $error("no xfer");
  AST_ONLY_D: assert property (xfer_pulse |-> $past(buf_wr && buf_idx == 3'h4))
    else $error("xfer without d");
  AST_BLOCK: assert property (ch4_oe_b == (buffer_mode_a | buffer_mode_b)) else $error("oe");
  AST_QUIET: assert property (ch4_oe_b |-> !ch4_c_pin && !ch4_d_pin) else $error("pins");
  AST_POL: assert property ($past(rst_b) |->
    out_pos == $past(raw_pos ^ ~{phase_pos_level_sel, pos_level_sel})) else $error("pol");
  AST_NODT: assert property ($past(rst_b) && !$past(deadtime_enable) |->
    out_neg == ~out_pos) else $error("neg");
endmodule
bind cpb_top cpb_properties chk_u (.clk, .rst_b, .buf_wr, .buf_idx, .buffer_mode_a,
  .buffer_mode_b, .deadtime_enable, .pos_level_sel, .phase_pos_level_sel, .raw_pos,
  .xfer_pulse, .out_pos, .out_neg, .ch3_c_pin_oe_b, .ch4_oe_b, .ch4_c_pin, .ch4_d_pin);
